// >>> mqwps_pkg.sv
package mqwps_pkg;

  // =====================================================================
  // address bus layout
  localparam int ADDR_W      = 7;
  localparam int QSEL_W      = 4;
  localparam int QSEL_LSB    = 0;
  localparam int DEV_ID_W    = 3;
  localparam int DEV_ID_LSB  = 4;
  localparam int SECTOR_BIT  = 0;
  localparam int NUM_QUEUES  = 16;
  localparam int NUM_DEVICES = 8;
  localparam int FLAG_BUS_W  = 8;
  localparam int NUM_SECTORS = 2;

  // =====================================================================
  // reset values and timing
  localparam logic [QSEL_W-1:0] QSEL_RST   = 4'h0;
  localparam logic              SECTOR_RST = 1'h0;
  // edges from selection edge until the new queue takes data
  localparam int SWITCH_EDGES = 2;

endpackage

// >>> mqwps_flag_mux.sv
`timescale 1ns/1ps

// =====================================================================
// flag bus register: direct sector or polled rotation
module mqwps_flag_mux
  import mqwps_pkg::*;
(
  // clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_i,
  // control
  input  wire logic                  polled_mode_i,
  input  wire logic                  sector_i,
  input  wire logic [NUM_QUEUES-1:0] almost_full_i,
  // flag bus
  output logic [FLAG_BUS_W-1:0]      almost_full_flag_bus_n_o,
  output logic                       poll_sector_o
);

  logic                  poll_ff;
  logic                  nxt_poll;
  logic                  shown_sector;
  logic [FLAG_BUS_W-1:0] nxt_bus_n;

  // polling advances every edge, independent of write enable
  assign nxt_poll     = ~poll_ff;
  assign shown_sector = polled_mode_i ? poll_ff : sector_i;
  assign nxt_bus_n    = shown_sector
                      ? ~almost_full_i[NUM_QUEUES-1:FLAG_BUS_W]
                      : ~almost_full_i[FLAG_BUS_W-1:0];

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      poll_ff                  <= 1'h0;
      almost_full_flag_bus_n_o <= 8'hFF;
      poll_sector_o            <= 1'h0;
    end else begin
      poll_ff                  <= polled_mode_i ? nxt_poll : 1'h0;
      almost_full_flag_bus_n_o <= nxt_bus_n;
      poll_sector_o            <= shown_sector;
    end
  end

endmodule

// >>> mqwps_write_port.sv
`timescale 1ns/1ps

module mqwps_write_port
  import mqwps_pkg::*;
#(
  parameter int DATA_W = 18
)(
  // clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_i,
  // configuration
  input  wire logic [DEV_ID_W-1:0]   device_id_i,
  input  wire logic                  polled_mode_i,
  // write port
  input  wire logic                  write_enable_n_i,
  input  wire logic [DATA_W-1:0]     write_data_i,
  input  wire logic                  write_queue_select_strobe_i,
  input  wire logic                  flag_sector_strobe_i,
  input  wire logic [ADDR_W-1:0]     write_queue_address_i,
  // queue status from storage
  input  wire logic [NUM_QUEUES-1:0] almost_full_i,
  // to queue storage
  output logic                       store_valid_o,
  output logic [QSEL_W-1:0]          store_queue_o,
  output logic [DATA_W-1:0]          store_data_o,
  // status
  output logic [QSEL_W-1:0]          active_queue_o,
  output logic                       sector_o,
  output logic                       poll_sector_o,
  output logic [FLAG_BUS_W-1:0]      almost_full_flag_bus_n_o
);

  initial begin
    if (DATA_W < 1) $error("DATA_W must be at least 1");
    if (ADDR_W != DEV_ID_LSB + DEV_ID_W) begin
      $error("address layout does not fill the address bus");
    end
    if (NUM_QUEUES != (1 << QSEL_W)) begin
      $error("queue field does not span all queues");
    end
    if (NUM_DEVICES != (1 << DEV_ID_W)) begin
      $error("id field does not span all devices");
    end
    if (FLAG_BUS_W * NUM_SECTORS != NUM_QUEUES) begin
      $error("flag sectors do not cover all queues");
    end
  end

  // =====================================================================
  // address decode
  logic              id_match;
  logic              queue_sel;
  logic              sector_sel;
  logic [QSEL_W-1:0] addr_queue;
  logic              addr_sector;

  assign id_match    = write_queue_address_i[DEV_ID_LSB +: DEV_ID_W]
                       == device_id_i;
  assign addr_queue  = write_queue_address_i[QSEL_LSB +: QSEL_W];
  // strobe is taken regardless of write enable
  assign queue_sel   = write_queue_select_strobe_i & id_match;
  // bits three to one are not looked at
  assign addr_sector = write_queue_address_i[SECTOR_BIT];
  assign sector_sel  = flag_sector_strobe_i & id_match
                       & ~polled_mode_i;

  // =====================================================================
  // queue selection pipeline
  logic [QSEL_W-1:0] pend_queue_ff;
  logic              pend_valid_ff;
  logic [QSEL_W-1:0] active_queue_ff;
  logic [QSEL_W-1:0] nxt_active_queue;
  logic              sector_ff;
  logic              nxt_sector;
  logic              store_now;

  // pending choice becomes active one edge after the selection edge,
  // so the selection edge and the next still use the old queue
  assign nxt_active_queue = pend_valid_ff ? pend_queue_ff
                                          : active_queue_ff;
  assign nxt_sector = sector_sel ? addr_sector : sector_ff;
  assign store_now  = ~write_enable_n_i;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_queue_ff   <= QSEL_RST;
      pend_valid_ff   <= 1'h0;
      active_queue_ff <= QSEL_RST;
      sector_ff       <= SECTOR_RST;
    end else begin
      if (queue_sel) begin
        pend_queue_ff <= addr_queue;
      end
      pend_valid_ff   <= queue_sel;
      active_queue_ff <= nxt_active_queue;
      sector_ff       <= nxt_sector;
    end
  end

  // =====================================================================
  // store strobe to queue storage
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      store_valid_o  <= 1'h0;
      store_queue_o  <= QSEL_RST;
      store_data_o   <= '0;
      active_queue_o <= QSEL_RST;
      sector_o       <= SECTOR_RST;
    end else begin
      store_valid_o  <= store_now;
      store_queue_o  <= active_queue_ff;
      store_data_o   <= write_data_i;
      active_queue_o <= nxt_active_queue;
      sector_o       <= nxt_sector;
    end
  end

  // =====================================================================
  // flag bus
  mqwps_flag_mux u_flag_mux (
    .ref_clk_i                (ref_clk_i),
    .rst_i                    (rst_i),
    .polled_mode_i            (polled_mode_i),
    .sector_i                 (sector_ff),
    .almost_full_i            (almost_full_i),
    .almost_full_flag_bus_n_o (almost_full_flag_bus_n_o),
    .poll_sector_o            (poll_sector_o)
  );

endmodule

// >>> mqwps_chk.sv
`timescale 1ns/1ps
// ==========
// write port checker
module mqwps_chk
  import mqwps_pkg::*;
(
  // clock, reset, config
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic [2:0] device_id_i,
  input wire logic       polled_mode_i,
  // write port
  input wire logic       write_enable_n_i,
  input wire logic       write_queue_select_strobe_i,
  input wire logic       flag_sector_strobe_i,
  input wire logic [6:0] write_queue_address_i,
  // outputs
  input wire logic       store_valid_o,
  input wire logic [3:0] store_queue_o,
  input wire logic [3:0] active_queue_o,
  input wire logic       sector_o,
  input wire logic       poll_sector_o
);
  wire logic hit = write_queue_address_i[6:4] == device_id_i;
  wire logic qsel = write_queue_select_strobe_i & hit;
  wire logic fsel = flag_sector_strobe_i & hit & ~polled_mode_i;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_store_on_wen: assert property (
    ##1 store_valid_o == $past(~write_enable_n_i)) else $error("bad store");
  a_store_queue: assert property (
    store_valid_o |-> store_queue_o == $past(active_queue_o))
    else $error("bad store queue");
  a_sel_taken: assert property (qsel |-> ##2
    active_queue_o == $past(write_queue_address_i[3:0], 2))
    else $error("select lost");
  a_sel_ignored: assert property (
    !qsel |-> ##2 $stable(active_queue_o)) else $error("stray select");
  a_sector_take: assert property (fsel |=>
    sector_o == $past(write_queue_address_i[0])) else $error("bad sector");
  a_sector_hold: assert property (
    !fsel |=> $stable(sector_o)) else $error("stray sector");
  a_poll_turn: assert property (
    polled_mode_i && $past(polled_mode_i) && !$past(rst_i)
    |=> poll_sector_o != $past(poll_sector_o))
    else $error("poll stuck");
endmodule

bind mqwps_write_port mqwps_chk mqwps_chk_inst (.*);

// >>> mqwps_host.sv
`timescale 1ns/1ps
// ==========
// writer model, one edge per call
module mqwps_host (
  input  wire logic ref_clk_i,
  output logic        en_n_o,
  output logic [17:0] d_o,
  output logic        qs_o,
  output logic        fs_o,
  output logic [6:0]  a_o
);
  initial {en_n_o, d_o, qs_o, fs_o, a_o} = {1'h1, 27'h0};
  // idle lines do not keep the last value
  task automatic cyc(input logic w, q, f, input logic [6:0] a,
                     input logic [17:0] d);
    @(posedge ref_clk_i);
    en_n_o <= ~w;
    d_o    <= w ? d : ~d;
    qs_o   <= q & ~f;
    fs_o   <= f;
    a_o    <= (q | f) ? a : ~a;
  endtask
endmodule

// >>> mqwps_write_port_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t mismatch", $time); end end
// ==========
// write port bench
module mqwps_write_port_tb;
  logic        ref_clk_i = 1'h0, rst_i = 1'h1, polled_mode_i = 1'h0;
  logic [2:0]  device_id_i = 3'h2;
  logic [15:0] almost_full_i = 16'h0;
  wire logic   write_enable_n_i, write_queue_select_strobe_i;
  wire logic   flag_sector_strobe_i;
  wire logic [17:0] write_data_i;
  wire logic [6:0]  write_queue_address_i;
  logic        store_valid_o, sector_o, poll_sector_o;
  logic [3:0]  store_queue_o, active_queue_o;
  logic [17:0] store_data_o;
  logic [7:0]  almost_full_flag_bus_n_o;
  int          fails = 0, cmp_count = 0, cycles = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  mqwps_write_port mqwps_write_port_inst (.*);
  mqwps_host mqwps_host_inst (.ref_clk_i(ref_clk_i),
    .en_n_o(write_enable_n_i), .d_o(write_data_i),
    .qs_o(write_queue_select_strobe_i), .fs_o(flag_sector_strobe_i),
    .a_o(write_queue_address_i));
  task automatic stop_test;
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // drive one edge, judge the store of the edge before
  task automatic step(input logic w, q, f, input logic [6:0] a,
    input logic [17:0] d, input logic ev, input logic [3:0] eq,
    input logic [17:0] ed);
    mqwps_host_inst.cyc(w, q, f, a, d);
    #1 `CHK(store_valid_o, ev)
    if (ev) begin
      `CHK(store_queue_o, eq)
      `CHK(store_data_o, ed)
    end
  endtask
  task automatic t_switch;
    step(1, 1, 0, 7'h25, 18'h11, 0, 0, 0);
    step(1, 0, 0, 7'h00, 18'h22, 1, 0, 18'h11);
    step(1, 0, 0, 7'h00, 18'h33, 1, 0, 18'h22);
    `CHK(active_queue_o, 4'h5)
    step(0, 0, 0, 7'h00, 18'h00, 1, 5, 18'h33);
  endtask
  task automatic t_mismatch;
    step(0, 1, 0, 7'h3A, 18'h00, 0, 0, 0);
    step(0, 1, 0, 7'h27, 18'h00, 0, 0, 0);
    step(1, 0, 0, 7'h00, 18'h44, 0, 0, 0);
    step(1, 0, 0, 7'h00, 18'h55, 1, 5, 18'h44);
    step(0, 0, 0, 7'h00, 18'h00, 1, 7, 18'h55);
  endtask
  task automatic t_sector;
    step(1, 0, 1, 7'h2F, 18'h66, 0, 0, 0);
    almost_full_i <= 16'hA55A;
    step(0, 0, 0, 7'h00, 18'h00, 1, 7, 18'h66);
    repeat (2) step(0, 0, 0, 7'h00, 18'h00, 0, 0, 0);
    `CHK(sector_o, 1'h1)
    `CHK(almost_full_flag_bus_n_o, 8'h5A)
  endtask
  task automatic t_polled;
    logic p;
    @(posedge ref_clk_i);
    rst_i <= 1'h1;
    polled_mode_i <= 1'h1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'h0;
    repeat (3) @(posedge ref_clk_i);
    #1 p = poll_sector_o;
    @(posedge ref_clk_i);
    #1 `CHK(poll_sector_o, ~p)
  endtask
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'h0;
    t_switch();
    t_mismatch();
    t_sector();
    t_polled();
    stop_test();
  end
endmodule
